// >>> verilog/msc_pkg.sv
`default_nettype none
package msc_pkg;
   // Command codes
   localparam logic [7:0] POSITION_CLEAR_CMD       = 8'hd8;
   localparam logic [7:0] DEVICE_RESET_CMD         = 8'hc0;
   localparam logic [7:0] CONTROLLED_STOP_CMD      = 8'hb0;
   localparam logic [7:0] IMMEDIATE_STOP_CMD       = 8'hb8;
   localparam logic [7:0] RAMPED_BRIDGE_OFF_CMD    = 8'ha0;
   localparam logic [7:0] IMMEDIATE_BRIDGE_OFF_CMD = 8'ha8;
   localparam logic [7:0] STATUS_READ_CMD          = 8'hd0;

   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 32;
   localparam int SPEED_W = 16;
   localparam int POS_W   = 22;
   localparam int WARN_W  = 4;
   localparam int IRQ_W   = 4;

   // Register byte addresses
   localparam logic [7:0] STATUS_OFS  = 8'h00;
   localparam logic [7:0] INT_STAT_OFS = 8'h04;
   localparam logic [7:0] INT_CLR_OFS = 8'h08;
   localparam logic [7:0] INT_EN_OFS  = 8'h0c;
   localparam logic [7:0] DECEL_OFS   = 8'h10;
   localparam logic [7:0] RUN_OFS     = 8'h14;
   localparam logic [7:0] POSITION_OFS = 8'h18;

   // Status word layout and run register direction bit
   localparam int STAT_BRIDGE_OFF = 0;
   localparam int STAT_BUSY_N     = 1;
   localparam int STAT_ERROR      = 2;
   localparam int STAT_WARN_LO    = 3;
   localparam int STAT_DIR        = 7;
   localparam int RUN_DIR_BIT   = 16;

   // Interrupt event bits
   localparam int IRQ_CMD        = 0;
   localparam int IRQ_STOPPED    = 1;
   localparam int IRQ_BRIDGE_OFF = 2;
   localparam int IRQ_WARN       = 3;

   // Values after reset, plus readback state and last-bit count
   localparam logic [15:0] DECEL_RST   = 16'h0010;
   localparam logic [3:0]  INT_EN_RST  = 4'h0;
   localparam logic [1:0]  TX_READBACK = 2'h2;
   localparam logic [2:0]  BIT_LAST    = 3'h7;
endpackage
`default_nettype wire

// >>> verilog/msc_sync.sv
`default_nettype none
module msc_sync #(
   parameter int W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         reset,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } msc_sync_state_t;

   msc_sync_state_t s_r;
   msc_sync_state_t s_nxt;

   always_comb
   begin
      s_nxt    = s_r;
      s_nxt.s1 = d;
      s_nxt.s2 = s_r.s1;
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         // Serial pins idle high; a low reset value would fake an edge
         s_r <= '1;
      else if (ce)
         s_r <= s_nxt;
   end

   assign q = s_r.s2;
endmodule
`default_nettype wire

// >>> verilog/msc_spi.sv
`default_nettype none
// Serial byte port, clock idles high, data sampled on the rising edge
module msc_spi (
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       ce,
   input  wire logic       sck_s,
   input  wire logic       cs_n_s,
   input  wire logic       sdi_s,
   input  wire logic       tx_load,
   input  wire logic [7:0] tx_byte,
   output logic      [7:0] rx_byte,
   output logic            rx_valid,
   output logic            sdo,
   output logic            sdo_en_n
);
   typedef struct packed {
      logic       sck_d;
      logic [2:0] cnt;
      logic [7:0] shin;
      logic [7:0] shout;
      logic [7:0] rx_byte;
      logic       rx_valid;
      logic       sdo_en_n;
   } msc_spi_state_t;

   msc_spi_state_t s_r;
   msc_spi_state_t s_nxt;

   always_comb
   begin
      s_nxt          = s_r;
      s_nxt.rx_valid = 1'b0;
      s_nxt.sck_d    = sck_s;
      s_nxt.sdo_en_n = cs_n_s;
      if (cs_n_s)
      begin
         s_nxt.cnt   = '0;
         s_nxt.shout = '0;
      end
      else if (sck_s && !s_r.sck_d)
      begin
         s_nxt.shin = {s_r.shin[6:0], sdi_s};
         s_nxt.cnt  = s_r.cnt + 3'h1;
         if (s_r.cnt == msc_pkg::BIT_LAST)
         begin
            s_nxt.rx_byte  = {s_r.shin[6:0], sdi_s}; // [R18]
            s_nxt.rx_valid = 1'b1;
         end
      end
      else if (!sck_s && s_r.sck_d && s_r.cnt != 3'h0)
         s_nxt.shout = {s_r.shout[6:0], 1'b0};
      if (tx_load && !cs_n_s)
         s_nxt.shout = tx_byte;
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         s_r <= '{sck_d: 1'b1, sdo_en_n: 1'b1, default: '0};
      else if (ce)
         s_r <= s_nxt;
   end

   assign rx_byte  = s_r.rx_byte;
   assign rx_valid = s_r.rx_valid;
   assign sdo      = s_r.shout[7];
   assign sdo_en_n = s_r.sdo_en_n;
endmodule
`default_nettype wire

// >>> verilog/msc_top.sv
// Strobed register access and the register offsets were decided locally.
`default_nettype none
// Contract
// [R1] Position clear command zeroes position counter
// [R2] Device reset returns logic to power-up
// [R3] Device reset acts only with bridges off
// [R4] Controlled stop ramps speed down, then stops
// [R5] Controlled stop with bridges off: enable, no move
// [R6] Immediate stop halts stepping at once
// [R7] Immediate stop with bridges off: enable, no move
// [R8] Stops and bridge-offs always accepted; busy low
// [R9] Ramped bridge off: ramp, disable, set flag
// [R10] Ramped bridge off when stopped: disable directly
// [R11] Immediate bridge off: disable now, set flag
// [R12] Immediate bridge off when stopped: disable bridges
// [R13] Status read returns two status bytes
// [R14] Status read clears warning flags
// [R15] Status read leaves any error state
// [R16] Status read keeps bridge-off flag unchanged
// [R17] Bridges stay disabled after power-up
// [R18] Bytes MSB first; unknown codes ignored
module msc_top (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        ce,
   input  wire logic        spi_sck,
   input  wire logic        spi_cs_n,
   input  wire logic        spi_sdi,
   output logic             spi_sdo,
   output logic             spi_sdo_en_n,
   input  wire logic [3:0]  warn_in,
   input  wire logic        fault_in,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wr_data,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [31:0] rd_data,
   output logic             irq,
   output logic             bridge_off,
   output logic             busy_n,
   output logic             step,
   output logic             dir
);
   typedef enum logic [1:0] {
      MOT_IDLE,
      MOT_RUN,
      MOT_RAMP
   } msc_mot_t;

   typedef struct packed {
      msc_mot_t    mot;
      logic        off_after;
      logic [15:0] speed;
      logic [15:0] acc;
      logic        dir;
      logic [21:0] pos;
      logic        bridge_off;
      logic        busy_n;
      logic        step;
      logic [3:0]  warn;
      logic        error;
      logic [15:0] decel;
      logic [3:0]  int_stat;
      logic [3:0]  int_en;
      logic        irq;
      logic [31:0] rd_data;
      logic [1:0]  tx_pend;
      logic        tx_load;
      logic [7:0]  tx_byte;
      logic [7:0]  tx_lo;
   } msc_main_t;

   function automatic msc_main_t power_up();
      msc_main_t p;
      p            = '0;
      p.mot        = MOT_IDLE;
      p.bridge_off = 1'b1; // [R17]
      p.busy_n     = 1'b1;
      p.decel      = msc_pkg::DECEL_RST;
      p.int_en     = msc_pkg::INT_EN_RST;
      return p;
   endfunction

   localparam msc_main_t MAIN_RST = power_up();

   msc_main_t   s_r;
   msc_main_t   s_nxt;
   logic [2:0]  pins_s;
   logic [7:0]  rx_byte;
   logic        rx_valid;
   logic [15:0] status_w;

   msc_sync #(
      .W (3)
   ) u_sync (
      .ref_clk (ref_clk),
      .reset   (reset),
      .ce      (ce),
      .d       ({spi_sck, spi_cs_n, spi_sdi}),
      .q       (pins_s)
   );

   msc_spi u_spi (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .ce       (ce),
      .sck_s    (pins_s[2]),
      .cs_n_s   (pins_s[1]),
      .sdi_s    (pins_s[0]),
      .tx_load  (s_r.tx_load),
      .tx_byte  (s_r.tx_byte),
      .rx_byte  (rx_byte),
      .rx_valid (rx_valid),
      .sdo      (spi_sdo),
      .sdo_en_n (spi_sdo_en_n)
   );

   always_comb
   begin
      status_w = '0;
      status_w[msc_pkg::STAT_BRIDGE_OFF] = s_r.bridge_off;
      status_w[msc_pkg::STAT_BUSY_N] = s_r.busy_n;
      status_w[msc_pkg::STAT_ERROR] = s_r.error;
      status_w[msc_pkg::STAT_WARN_LO +: msc_pkg::WARN_W] = s_r.warn;
      status_w[msc_pkg::STAT_DIR] = s_r.dir;
   end

   always_comb
   begin
      logic        is_cmd;
      logic        warn_clr;
      logic        reset_req;
      logic [3:0]  ev;
      logic [16:0] sum;
      is_cmd    = rx_valid && (s_r.tx_pend == 2'h0);
      warn_clr  = 1'b0;
      reset_req = 1'b0;
      ev        = '0;
      sum       = '0;
      s_nxt         = s_r;
      s_nxt.step    = 1'b0;
      s_nxt.tx_load = 1'b0;
      s_nxt.rd_data = '0;

      // Step generation and deceleration ramp
      if (s_r.mot != MOT_IDLE)
      begin
         sum       = {1'b0, s_r.acc} + {1'b0, s_r.speed};
         s_nxt.acc = sum[15:0];
         if (sum[16])
         begin
            s_nxt.step = 1'b1;
            if (s_r.dir)
               s_nxt.pos = s_r.pos + 22'h1;
            else
               s_nxt.pos = s_r.pos - 22'h1;
         end
      end
      case (s_r.mot)
         MOT_IDLE:
            s_nxt.speed = '0;
         MOT_RUN:
            s_nxt.speed = s_r.speed;
         MOT_RAMP:
         begin
            if (s_r.speed <= s_r.decel)
            begin
               s_nxt.speed = '0;
               s_nxt.mot   = MOT_IDLE;
               if (s_r.off_after)
                  s_nxt.bridge_off = 1'b1; // [R9]
            end
            else
               s_nxt.speed = s_r.speed - s_r.decel; // [R4]
         end
         default:
            s_nxt.mot = MOT_IDLE;
      endcase

      // A fault while no error is flagged forces the error state and drops the bridges
      if (fault_in && !s_r.error)
      begin
         s_nxt.error      = 1'b1;
         s_nxt.bridge_off = 1'b1;
         s_nxt.mot        = MOT_IDLE;
         s_nxt.speed      = '0;
      end

      // Register writes
      if (wr_en)
      begin
         case (addr)
            msc_pkg::INT_CLR_OFS:
               s_nxt.int_stat = s_r.int_stat & ~wr_data[3:0];
            msc_pkg::INT_EN_OFS:
               s_nxt.int_en = wr_data[3:0];
            msc_pkg::DECEL_OFS:
               s_nxt.decel = wr_data[15:0];
            msc_pkg::RUN_OFS:
            begin
               if (!s_r.bridge_off && !s_r.error && s_r.mot == MOT_IDLE && wr_data[15:0] != 16'h0)
               begin
                  s_nxt.speed = wr_data[15:0];
                  s_nxt.dir   = wr_data[msc_pkg::RUN_DIR_BIT];
                  s_nxt.acc   = '0;
                  s_nxt.mot   = MOT_RUN;
               end
            end
            default:
               s_nxt.int_en = s_r.int_en;
         endcase
      end

      // Readback bytes after a status read carry no command
      if (rx_valid && s_r.tx_pend == msc_pkg::TX_READBACK)
      begin
         s_nxt.tx_byte = s_r.tx_lo; // [R13]
         s_nxt.tx_load = 1'b1;
         s_nxt.tx_pend = 2'h1;
      end
      else if (rx_valid && s_r.tx_pend == 2'h1)
      begin
         s_nxt.tx_byte = '0;
         s_nxt.tx_load = 1'b1;
         s_nxt.tx_pend = 2'h0;
      end

      // Command decode; takes effect at once in any motion state
      if (is_cmd)
      begin
         ev[msc_pkg::IRQ_CMD] = 1'b1;
         case (rx_byte)
            msc_pkg::POSITION_CLEAR_CMD:
               s_nxt.pos = '0; // [R1]
            msc_pkg::DEVICE_RESET_CMD:
            begin
               if (s_r.bridge_off)
                  reset_req = 1'b1; // [R2] [R3]
            end
            msc_pkg::CONTROLLED_STOP_CMD:
            begin
               if (s_r.bridge_off)
               begin
                  s_nxt.bridge_off = 1'b0; // [R5]
                  s_nxt.mot        = MOT_IDLE;
                  s_nxt.speed      = '0;
               end
               else if (s_r.mot != MOT_IDLE)
               begin
                  s_nxt.mot       = MOT_RAMP; // [R4] [R8]
                  s_nxt.off_after = 1'b0;
               end
            end
            msc_pkg::IMMEDIATE_STOP_CMD:
            begin
               if (s_r.bridge_off)
                  s_nxt.bridge_off = 1'b0; // [R7]
               s_nxt.mot   = MOT_IDLE; // [R6] [R8]
               s_nxt.speed = '0;
               s_nxt.step  = 1'b0;
            end
            msc_pkg::RAMPED_BRIDGE_OFF_CMD:
            begin
               if (s_r.mot == MOT_IDLE)
                  s_nxt.bridge_off = 1'b1; // [R10]
               else
               begin
                  s_nxt.mot       = MOT_RAMP; // [R9] [R8]
                  s_nxt.off_after = 1'b1;
               end
            end
            msc_pkg::IMMEDIATE_BRIDGE_OFF_CMD:
            begin
               s_nxt.mot        = MOT_IDLE; // [R11] [R12] [R8]
               s_nxt.speed      = '0;
               s_nxt.step       = 1'b0;
               s_nxt.bridge_off = 1'b1;
            end
            msc_pkg::STATUS_READ_CMD:
            begin
               s_nxt.tx_byte = status_w[15:8]; // [R13]
               s_nxt.tx_lo   = status_w[7:0];
               s_nxt.tx_load = 1'b1;
               s_nxt.tx_pend = msc_pkg::TX_READBACK;
               warn_clr      = 1'b1; // [R14]
               s_nxt.error   = 1'b0; // [R15]
               // Bridge-off flag left as it stands [R16]
            end
            default:
               ev[msc_pkg::IRQ_CMD] = 1'b0; // [R18]
         endcase
      end

      // Warnings are sticky; a new warning wins over the clear
      s_nxt.warn = (warn_clr ? 4'h0 : s_r.warn) | warn_in; // [R14]

      s_nxt.busy_n = (s_nxt.mot == MOT_IDLE); // [R8]

      ev[msc_pkg::IRQ_STOPPED]    = (s_r.mot != MOT_IDLE) && (s_nxt.mot == MOT_IDLE);
      ev[msc_pkg::IRQ_BRIDGE_OFF] = !s_r.bridge_off && s_nxt.bridge_off;
      ev[msc_pkg::IRQ_WARN]       = (|warn_in) || (fault_in && !s_r.error);
      s_nxt.int_stat = s_nxt.int_stat | ev;

      // Register reads, data stand in the following cycle
      if (rd_en)
      begin
         case (addr)
            msc_pkg::STATUS_OFS:
               s_nxt.rd_data = {16'h0, status_w};
            msc_pkg::INT_STAT_OFS:
               s_nxt.rd_data = {28'h0, s_r.int_stat};
            msc_pkg::INT_EN_OFS:
               s_nxt.rd_data = {28'h0, s_r.int_en};
            msc_pkg::DECEL_OFS:
               s_nxt.rd_data = {16'h0, s_r.decel};
            msc_pkg::RUN_OFS:
               s_nxt.rd_data = {15'h0, s_r.dir, s_r.speed};
            msc_pkg::POSITION_OFS:
               s_nxt.rd_data = {10'h0, s_r.pos};
            default:
               s_nxt.rd_data = '0;
         endcase
      end

      if (reset_req)
         s_nxt = MAIN_RST; // [R2]

      s_nxt.irq = |(s_nxt.int_stat & s_nxt.int_en);
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         s_r <= MAIN_RST;
      else if (ce)
         s_r <= s_nxt;
   end

   assign rd_data    = s_r.rd_data;
   assign irq        = s_r.irq;
   assign bridge_off = s_r.bridge_off;
   assign busy_n     = s_r.busy_n;
   assign step       = s_r.step;
   assign dir        = s_r.dir;
endmodule
`default_nettype wire

// >>> sim/msc_properties.sv
`default_nettype none
module msc_properties (
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic        spi_cs_n,
   input wire logic        spi_sdo_en_n,
   input wire logic [7:0]  addr,
   input wire logic [31:0] wr_data,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [31:0] rd_data,
   input wire logic        irq,
   input wire logic        bridge_off,
   input wire logic        busy_n,
   input wire logic        step
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] since_r;

   // Cycles since chip select was last seen low, saturating
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         since_r <= 4'hf;
      else if (!spi_cs_n)
         since_r <= 4'h0;
      else if (since_r != 4'hf)
         since_r <= since_r + 4'h1;
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   property p_sdo_off;
      spi_cs_n [*5] |-> spi_sdo_en_n;
   endproperty
   a_sdo_off: assert property (p_sdo_off) else $error("sdo driven while deselected");
   property p_sdo_on;
      !spi_cs_n [*5] |-> !spi_sdo_en_n;
   endproperty
   a_sdo_on: assert property (p_sdo_on) else $error("sdo not driven while selected");
   property p_fall_cmd;
      $fell(bridge_off) |-> since_r < 4'hc;
   endproperty
   a_fall_cmd: assert property (p_fall_cmd) else $error("bridges enabled without command");
   property p_idle_hold;
      bridge_off && busy_n |=> busy_n;
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("motion with bridges off");
   property p_idle_step;
      busy_n [*3] |-> !step;
   endproperty
   a_idle_step: assert property (p_idle_step) else $error("step while idle");
   property p_off_step;
      bridge_off [*2] |-> !step;
   endproperty
   a_off_step: assert property (p_off_step) else $error("step with bridges off");
   property p_irq_mask;
      wr_en && addr == msc_pkg::INT_EN_OFS && wr_data[3:0] == 4'h0 |-> ##3 !irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq not masked");
   property p_rd_idle;
      !rd_en |=> rd_data == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
   property p_rd_gap;
      rd_en && addr == 8'h1c |=> rd_data == 32'h0;
   endproperty
   a_rd_gap: assert property (p_rd_gap) else $error("unmapped read not zero");
endmodule
`default_nettype wire

// >>> sim/msc_host.sv
`default_nettype none
module msc_host (
   input  wire logic ref_clk,
   output logic      sck,
   output logic      cs_n,
   output logic      sdi,
   input  wire logic sdo
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      sck = 1'b1;
      cs_n = 1'b1;
      sdi = 1'b0;
   end

   // Released data line toggles so a stale bit is never read as data
   always @(posedge ref_clk)
      if (cs_n)
         sdi <= ~sdi;

   task automatic shift(input logic [7:0] o, output logic [7:0] i);
      for (int k = 7; k >= 0; k--)
      begin
         @(posedge ref_clk);
         sck <= 1'b0;
         sdi <= o[k];
         repeat (5) @(posedge ref_clk);
         i[k] = sdo;
         sck <= 1'b1;
         repeat (5) @(posedge ref_clk);
      end
   endtask

   task automatic cmd(input logic [7:0] c);
      logic [7:0] r;
      @(posedge ref_clk);
      cs_n <= 1'b0;
      shift(c, r);
      repeat (10) @(posedge ref_clk);
      cs_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask

   task automatic status(output logic [15:0] s);
      logic [7:0] r;
      @(posedge ref_clk);
      cs_n <= 1'b0;
      shift(8'hd0, r);
      repeat (10) @(posedge ref_clk);
      shift(8'h00, s[15:8]);
      shift(8'h00, s[7:0]);
      repeat (4) @(posedge ref_clk);
      cs_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

// >>> sim/test_motor_stop_reset_status_cmds.sv
`default_nettype none
module test_motor_stop_reset_status_cmds;
   timeunit 1ns;
   timeprecision 1ps;

   logic        ref_clk;
   logic        reset;
   logic        wr_en;
   logic        rd_en;
   logic        fault_in;
   logic [3:0]  warn_in;
   logic [7:0]  addr;
   logic [31:0] wr_data;
   logic [31:0] rd_data;
   logic        spi_sck;
   logic        spi_cs_n;
   logic        spi_sdi;
   logic        spi_sdo;
   logic        spi_sdo_en_n;
   logic        irq;
   logic        bridge_off;
   logic        busy_n;
   logic        step;
   logic        dir;
   logic [31:0] pins;
   logic [31:0] v;
   logic [15:0] s;
   logic [15:0] spd;
   int          bad_count;
   int          samples_checked;
   int          cyc;
   int          steps;
   int          n0;
   logic        ce;
   logic [3:0]  w;
   logic [7:0]  codes [4] = '{8'hb8, 8'hb0, 8'ha0, 8'ha8};
   logic [31:0] mid [4] = '{32'h1, 32'h0, 32'h0, 32'h3};
   logic [31:0] fin [4] = '{32'h1, 32'h1, 32'h3, 32'h3};

   assign pins = {28'h0, dir, irq, bridge_off, busy_n};

   msc_top u_msc_top (.ref_clk(ref_clk), .reset(reset), .ce(ce), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_en_n(spi_sdo_en_n), .warn_in(warn_in), .fault_in(fault_in),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq),
      .bridge_off(bridge_off), .busy_n(busy_n), .step(step), .dir(dir));
   msc_host u_msc_host (.ref_clk(ref_clk), .sck(spi_sck), .cs_n(spi_cs_n), .sdi(spi_sdi), .sdo(spi_sdo));

   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic complete_run;
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         bad_count++;
         complete_run();
      end
   end

   // Step pulses seen on the output pin
   always @(posedge ref_clk)
      if (step === 1'b1)
         steps <= steps + 1;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask

   // Waits for busy_n (sel 0) or bridge_off (sel 1) to reach val
   task automatic wt(input logic sel, input logic val, input int lim);
      repeat (lim)
      begin
         if ((sel ? bridge_off : busy_n) === val)
            break;
         @(posedge ref_clk);
         #1;
      end
   endtask

   function automatic logic [31:0] stat(input logic bo, input logic [3:0] w);
      return {24'h0, 1'b0, w, 1'b0, 1'b1, bo};
   endfunction

   function automatic logic known(input logic [7:0] c);
      return c inside {8'hd8, 8'hc0, 8'hb0, 8'hb8, 8'ha0, 8'ha8, 8'hd0};
   endfunction

   initial
   begin
      reset = 1'b1;
      wr_en = 1'b0;
      rd_en = 1'b0;
      fault_in = 1'b0;
      ce = 1'b1;
      warn_in = 4'h0;
      addr = 8'h00;
      wr_data = 32'h0;
      cyc = 0;
      v = $urandom(32'h63aa0213);
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      rd(msc_pkg::STATUS_OFS, v);
      chk(v, stat(1'b1, 4'h0));
      rd(8'h1c, v);
      chk(v, 32'h0);
      wr(msc_pkg::INT_EN_OFS, 32'h1);
      u_msc_host.cmd(8'hd9);
      repeat (6)
      begin
         v = $urandom;
         if (!known(v[7:0]))
            u_msc_host.cmd(v[7:0]);
      end
      chk(pins & 32'h6, 32'h2);
      v = $urandom;
      w = v[3:0] | 4'h1;
      warn_in <= w;
      @(posedge ref_clk);
      warn_in <= 4'h0;
      u_msc_host.status(s);
      chk({16'h0, s}, stat(1'b1, w));
      rd(msc_pkg::STATUS_OFS, v);
      chk(v, stat(1'b1, 4'h0));
      chk(pins & 32'h4, 32'h4);
      wr(msc_pkg::INT_EN_OFS, 32'h0);
      repeat (3) @(posedge ref_clk);
      #1 chk(pins & 32'h4, 32'h0);
      rd(msc_pkg::INT_STAT_OFS, v);
      chk(v & 32'h1, 32'h1);
      wr(msc_pkg::INT_CLR_OFS, 32'h1);
      rd(msc_pkg::INT_STAT_OFS, v);
      chk(v & 32'h1, 32'h0);
      fault_in <= 1'b1;
      @(posedge ref_clk);
      fault_in <= 1'b0;
      rd(msc_pkg::STATUS_OFS, v);
      chk(v & 32'h5, 32'h5);
      u_msc_host.status(s);
      rd(msc_pkg::STATUS_OFS, v);
      chk(v & 32'h5, 32'h1);
      for (int i = 0; i < 2; i++)
      begin
         u_msc_host.cmd(8'ha8);
         chk(pins & 32'h3, 32'h3);
         u_msc_host.cmd(codes[i]);
         chk(pins & 32'h3, 32'h1);
      end
      u_msc_host.cmd(8'ha0);
      chk(pins & 32'h3, 32'h3);
      wr(msc_pkg::DECEL_OFS, 32'h40);
      // A write while the clock enable is low must be lost
      ce <= 1'b0;
      repeat ($urandom_range(3, 1)) @(posedge ref_clk);
      wr(msc_pkg::DECEL_OFS, 32'h20);
      ce <= 1'b1;
      rd(msc_pkg::DECEL_OFS, v);
      chk(v, 32'h40);
      for (int i = 0; i < 4; i++)
      begin
         v = $urandom;
         spd = 16'h0800 | (v[15:0] & 16'h03ff);
         u_msc_host.cmd(8'hb8);
         wr(msc_pkg::RUN_OFS, {15'h0, v[16], spd});
         n0 = steps;
         wt(1'b0, 1'b0, 10);
         chk(pins & 32'h9, {28'h0, v[16], 3'h0});
         u_msc_host.cmd(codes[i]);
         chk(pins & 32'h3, mid[i]);
         chk(32'(steps > n0), 32'h1);
         wt(1'b0, 1'b1, 100);
         wt(1'b1, fin[i][1], 100);
         chk(pins & 32'h3, fin[i]);
      end
      u_msc_host.cmd(8'hd8);
      rd(msc_pkg::POSITION_OFS, v);
      chk(v, 32'h0);
      u_msc_host.cmd(8'hb8);
      u_msc_host.cmd(8'hc0);
      rd(msc_pkg::DECEL_OFS, v);
      chk(v, 32'h40);
      u_msc_host.cmd(8'ha8);
      u_msc_host.cmd(8'hc0);
      rd(msc_pkg::DECEL_OFS, v);
      chk(v, 32'h10);
      rd(msc_pkg::STATUS_OFS, v);
      chk(v, stat(1'b1, 4'h0));
      complete_run();
   end
endmodule

bind msc_top msc_properties u_msc_properties (.ref_clk(ref_clk), .reset(reset), .spi_cs_n(spi_cs_n),
   .spi_sdo_en_n(spi_sdo_en_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
   .rd_data(rd_data), .irq(irq), .bridge_off(bridge_off), .busy_n(busy_n), .step(step));
`default_nettype wire
